// ==== src/cec_error_confinement.sv ====
`timescale 1ns/10ps
// Overview of operation
// - error active node signals detected errors with an active-error flag
// - error passive node uses only passive-error flags, never active ones
// - passive transmitter waits 8 extra recessive bits before next transmission
// - bus off node neither transmits nor receives until recovered
// - active both counts <=127; passive either >=128; bus off transmit >=256
// - error increments take effect at first bit of the error flag
// - all counter-change conditions in one operation are applied
// - receiver error adds 1, except bit error during own active/overload flag
// - receiver sees dominant first bit after its flag: add 8
// - transmitter sending an error flag adds 8, with exemptions
// - no transmit increment for passive ACK error or arbitration stuff error
// - transmitter bit error during active/overload flag adds 8
// - receiver bit error during active/overload flag adds 8
// - 14 dominant bits counted from active/overload flag start, then every 8: add 8
// - 8 dominant bits after passive flag, then every 8: add 8
// - successful transmission subtracts 1 from transmit count, floor zero
// - successful reception: decrement 1..127, keep zero, reload above 127
// - bus off clears both counters after 128 runs of 11 recessive bits
module cec_error_confinement (
	input wire logic clk,
	input wire logic rst,
	input wire logic bitTick,
	input wire logic rxBit,
	input wire logic isTransmitter,
	input wire logic errDetect,
	input wire logic bitErrInFlag,
	input wire logic ackErrNoDom,
	input wire logic stuffErrArb,
	input wire logic flagStart,
	input wire logic flagIsOverload,
	input wire logic flagDone,
	input wire logic txDone,
	input wire logic rxDone,
	input wire logic txRequest,
	output cec_pkg::cec_state_t faultState,
	output cec_pkg::cec_flag_t flagKind,
	output logic txAllowed,
	output logic rxAllowed,
	output logic [8:0] transmitFaultCount,
	output logic [8:0] receiveFaultCount
);
	// ---------------------------------------------
	// state decode
	// ---------------------------------------------
	logic [8:0] tec_r;
	logic [8:0] rec_r;
	cec_pkg::cec_state_t state;
	always_comb begin
		if (tec_r >= cec_pkg::BUSOFF_LIMIT)
			state = cec_pkg::ST_BUSOFF;
		else if (tec_r >= cec_pkg::PASSIVE_LIMIT || rec_r >= cec_pkg::PASSIVE_LIMIT)
			state = cec_pkg::ST_PASSIVE;
		else
			state = cec_pkg::ST_ACTIVE;
	end
	assign faultState = state;
	assign transmitFaultCount = tec_r;
	assign receiveFaultCount = rec_r;

	// ---------------------------------------------
	// flag selection
	// ---------------------------------------------
	logic suspendBusy;
	always_comb begin
		unique case (state)
			cec_pkg::ST_ACTIVE: flagKind = errDetect ? cec_pkg::FLAG_ACTIVE : cec_pkg::FLAG_NONE;
			cec_pkg::ST_PASSIVE: flagKind = errDetect ? cec_pkg::FLAG_PASSIVE : cec_pkg::FLAG_NONE;
			default: flagKind = cec_pkg::FLAG_NONE;
		endcase
	end
	assign txAllowed = (state != cec_pkg::ST_BUSOFF) && !suspendBusy && txRequest;
	assign rxAllowed = (state != cec_pkg::ST_BUSOFF);

	// ---------------------------------------------
	// flag tracking
	// ---------------------------------------------
	logic inFlag_r;
	logic flagActive_r;
	logic firstAfter_r;
	logic runOn_r;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			inFlag_r <= 1'b0;
		end else if (flagStart) begin
			inFlag_r <= 1'b1;
		end else if (flagDone) begin
			inFlag_r <= 1'b0;
		end
	end

	// active and overload flags use the longer first run
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			flagActive_r <= 1'b0;
		end else if (flagStart) begin
			flagActive_r <= (state == cec_pkg::ST_ACTIVE) || flagIsOverload;
		end
	end

	// marks the first bus bit after the own flag
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			firstAfter_r <= 1'b0;
		end else if (flagStart) begin
			firstAfter_r <= 1'b0;
		end else if (flagDone) begin
			firstAfter_r <= 1'b1;
		end else if (bitTick) begin
			firstAfter_r <= 1'b0;
		end
	end

	// keeps run counting open past the flag end until a recessive bit
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			runOn_r <= 1'b0;
		end else if (flagStart) begin
			runOn_r <= 1'b0;
		end else if (flagDone) begin
			runOn_r <= 1'b1;
		end else if (bitTick && rxBit) begin
			runOn_r <= 1'b0;
		end
	end

	logic firstDom;
	assign firstDom = firstAfter_r && bitTick && !rxBit && !isTransmitter;

	// ---------------------------------------------
	// dominant runs
	// ---------------------------------------------
	// counted from the flag start; any recessive bit restarts the run
	// passive flags are recessive, so their run starts after the flag
	logic [4:0] domRun_r;
	logic domFirstHit_r;
	logic tracking;
	logic runHit;
	logic [4:0] runTarget;
	assign tracking = inFlag_r || runOn_r;
	assign runTarget = (flagActive_r && !domFirstHit_r) ? cec_pkg::ACT_FLAG_DOM_FIRST : cec_pkg::DOM_GROUP;
	assign runHit = bitTick && !rxBit && tracking && (domRun_r + 5'h01 == runTarget);
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			domRun_r <= 5'h00;
		end else if (flagStart) begin
			domRun_r <= 5'h00;
		end else if (bitTick) begin
			if (rxBit || runHit) begin
				domRun_r <= 5'h00;
			end else if (tracking) begin
				domRun_r <= domRun_r + 5'h01;
			end
		end
	end

	// after the first hit every further group is the short one
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			domFirstHit_r <= 1'b0;
		end else if (flagStart) begin
			domFirstHit_r <= 1'b0;
		end else if (runHit) begin
			domFirstHit_r <= 1'b1;
		end
	end

	// ---------------------------------------------
	// suspend transmission
	// ---------------------------------------------
	logic [3:0] suspCnt_r;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			suspCnt_r <= 4'h0;
		end else if (txDone && state == cec_pkg::ST_PASSIVE) begin
			suspCnt_r <= cec_pkg::SUSPEND_BITS;
		end else if (bitTick && rxBit && suspCnt_r != 4'h0) begin
			suspCnt_r <= suspCnt_r - 4'h1;
		end
	end
	assign suspendBusy = suspCnt_r != 4'h0;

	// ---------------------------------------------
	// bus off recovery
	// ---------------------------------------------
	logic [3:0] recRun_r;
	logic [7:0] runCount_r;
	logic runEnd;
	logic recovered;
	assign runEnd = bitTick && rxBit && (recRun_r + 4'h1 == cec_pkg::IDLE_RUN_BITS);
	assign recovered = (state == cec_pkg::ST_BUSOFF) && runEnd && (runCount_r + 8'h01 == cec_pkg::RECOVERY_RUNS);
	// length of the current recessive run
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			recRun_r <= 4'h0;
		end else if (state != cec_pkg::ST_BUSOFF) begin
			recRun_r <= 4'h0;
		end else if (bitTick) begin
			if (!rxBit || runEnd) begin
				recRun_r <= 4'h0;
			end else begin
				recRun_r <= recRun_r + 4'h1;
			end
		end
	end

	// complete recessive runs seen while bus off
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			runCount_r <= 8'h00;
		end else if (state != cec_pkg::ST_BUSOFF) begin
			runCount_r <= 8'h00;
		end else if (runEnd) begin
			runCount_r <= runCount_r + 8'h01;
		end
	end

	// ---------------------------------------------
	// counter updates
	// ---------------------------------------------
	logic ackExempt;
	logic txFlagInc;
	logic rxErrInc;
	logic txBitInc;
	logic rxBitInc;
	logic txRunInc;
	logic rxRunInc;
	assign ackExempt = (state == cec_pkg::ST_PASSIVE) && ackErrNoDom;
	assign txFlagInc = flagStart && isTransmitter && !stuffErrArb && !ackExempt;
	assign rxErrInc = flagStart && !isTransmitter && errDetect && !bitErrInFlag;
	assign txBitInc = bitErrInFlag && isTransmitter;
	assign rxBitInc = bitErrInFlag && !isTransmitter;
	assign txRunInc = runHit && isTransmitter;
	assign rxRunInc = runHit && !isTransmitter;

	// every term that applies in a cycle is added
	logic [8:0] tecAdd;
	logic [8:0] recAdd;
	always_comb begin
		tecAdd = cec_pkg::CNT_ZERO;
		recAdd = cec_pkg::CNT_ZERO;
		if (txFlagInc)
			tecAdd = tecAdd + cec_pkg::INC_LARGE;
		if (txBitInc)
			tecAdd = tecAdd + cec_pkg::INC_LARGE;
		if (txRunInc)
			tecAdd = tecAdd + cec_pkg::INC_LARGE;
		if (rxErrInc)
			recAdd = recAdd + cec_pkg::INC_SMALL;
		if (rxBitInc)
			recAdd = recAdd + cec_pkg::INC_LARGE;
		if (firstDom)
			recAdd = recAdd + cec_pkg::INC_LARGE;
		if (rxRunInc)
			recAdd = recAdd + cec_pkg::INC_LARGE;
	end

	logic [8:0] tecNxt;
	logic [8:0] recNxt;
	always_comb begin
		tecNxt = tec_r + tecAdd;
		if (txDone && tecNxt != cec_pkg::CNT_ZERO)
			tecNxt = tecNxt - cec_pkg::DEC_ONE;
		if (tecNxt < tec_r)
			tecNxt = tec_r - ((txDone && tec_r != cec_pkg::CNT_ZERO) ? cec_pkg::DEC_ONE : cec_pkg::CNT_ZERO);
		recNxt = rec_r + recAdd;
		if (recNxt < rec_r)
			recNxt = 9'h1FF;
		if (rxDone) begin
			if (recNxt > cec_pkg::RX_RELOAD)
				recNxt = cec_pkg::RX_RELOAD;
			else if (recNxt != cec_pkg::CNT_ZERO)
				recNxt = recNxt - cec_pkg::DEC_ONE;
		end
	end

	// counters freeze in bus off; only recovery clears them
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			tec_r <= cec_pkg::CNT_ZERO;
		end else if (state == cec_pkg::ST_BUSOFF) begin
			if (recovered) begin
				tec_r <= cec_pkg::CNT_ZERO;
			end
		end else begin
			tec_r <= tecNxt;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rec_r <= cec_pkg::CNT_ZERO;
		end else if (state == cec_pkg::ST_BUSOFF) begin
			if (recovered) begin
				rec_r <= cec_pkg::CNT_ZERO;
			end
		end else begin
			rec_r <= recNxt;
		end
	end
endmodule

// ==== src/cec_pkg.sv ====
package cec_pkg;
	// ---------------------------------------------
	// counter widths and thresholds
	// ---------------------------------------------
	localparam int CNT_W = 9;
	localparam logic [8:0] CNT_ZERO = 9'h000;
	localparam logic [8:0] PASSIVE_LIMIT = 9'h080;
	localparam logic [8:0] BUSOFF_LIMIT = 9'h100;
	localparam logic [8:0] RX_RELOAD = 9'h07F;
	localparam logic [8:0] INC_SMALL = 9'h001;
	localparam logic [8:0] INC_LARGE = 9'h008;
	localparam logic [8:0] DEC_ONE = 9'h001;
	// ---------------------------------------------
	// bit-count thresholds
	// ---------------------------------------------
	localparam logic [4:0] ACT_FLAG_DOM_FIRST = 5'h0E;
	localparam logic [4:0] DOM_GROUP = 5'h08;
	localparam logic [3:0] SUSPEND_BITS = 4'h8;
	localparam logic [3:0] IDLE_RUN_BITS = 4'hB;
	localparam logic [7:0] RECOVERY_RUNS = 8'h80;
	// ---------------------------------------------
	// fault state and flag kind
	// ---------------------------------------------
	typedef enum logic [1:0] {
		ST_ACTIVE = 2'b00,
		ST_PASSIVE = 2'b01,
		ST_BUSOFF = 2'b10
	} cec_state_t;
	typedef enum logic [1:0] {
		FLAG_NONE = 2'b00,
		FLAG_ACTIVE = 2'b01,
		FLAG_PASSIVE = 2'b10
	} cec_flag_t;
endpackage

// ==== tb/cec_bus_node.sv ====
`timescale 1ns/10ps
module cec_bus_node (
	input wire logic clk,
	input wire logic en,
	input wire logic lvl,
	output logic bitTick = 1'b0,
	output logic rxBit = 1'b1
);
	logic [1:0] ph = 2'h0;
	// released bus floats to recessive
	always @(negedge clk) begin
		ph <= en ? ph + 2'h1 : 2'h0;
		bitTick <= en && ph == 2'h3;
		rxBit <= en ? lvl : 1'b1;
	end
endmodule

// ==== tb/cec_error_confinement_sva.sv ====
`timescale 1ns/10ps
module cec_error_confinement_sva (
	input wire logic clk,
	input wire logic rst,
	input wire logic bitTick,
	input wire logic isTransmitter,
	input wire logic errDetect,
	input wire logic stuffErrArb,
	input wire logic ackErrNoDom,
	input wire logic flagStart,
	input wire logic txDone,
	input wire logic rxDone,
	input wire cec_pkg::cec_state_t faultState,
	input wire cec_pkg::cec_flag_t flagKind,
	input wire logic txAllowed,
	input wire logic rxAllowed,
	input wire logic [8:0] transmitFaultCount,
	input wire logic [8:0] receiveFaultCount
);
	default clocking @(posedge clk);
	endclocking
	default disable iff (rst);
	logic [8:0] tc;
	logic [8:0] rc;
	logic off;
	assign tc = transmitFaultCount;
	assign rc = receiveFaultCount;
	assign off = faultState == cec_pkg::ST_BUSOFF;
	a_state_decode: assert property (faultState == (tc > 9'h0FF ? cec_pkg::ST_BUSOFF :
		(tc > 9'h07F || rc > 9'h07F) ? cec_pkg::ST_PASSIVE : cec_pkg::ST_ACTIVE)) else $error("bad state");
	a_flag_active: assert property (errDetect && faultState == cec_pkg::ST_ACTIVE |->
		flagKind == cec_pkg::FLAG_ACTIVE) else $error("bad active flag");
	a_flag_passive: assert property (errDetect && faultState == cec_pkg::ST_PASSIVE |->
		flagKind == cec_pkg::FLAG_PASSIVE) else $error("bad passive flag");
	a_busoff_silent: assert property (off |-> !txAllowed && !rxAllowed) else $error("bus off active");
	a_tx_inc: assert property (flagStart && isTransmitter && !stuffErrArb && !bitTick && !txDone && !off
		&& !(ackErrNoDom && faultState == cec_pkg::ST_PASSIVE)
		|=> tc == $past(tc) + 9'h008) else $error("tx inc wrong");
	a_tx_exempt: assert property (flagStart && stuffErrArb && !bitTick && !txDone |=> $stable(tc))
		else $error("tx exempt wrong");
	a_tx_dec: assert property (txDone && !flagStart && !bitTick && !off |=>
		tc == ($past(tc) == 9'h000 ? 9'h000 : $past(tc) - 9'h001)) else $error("tx dec wrong");
	a_rx_reload: assert property (rxDone && rc > 9'h07F && !flagStart && !bitTick && !off |=>
		rc == 9'h07F) else $error("rx reload wrong");
	c_passive: cover property (faultState == cec_pkg::ST_PASSIVE);
	c_busoff: cover property (off);
	c_reload: cover property (rxDone && rc > 9'h07F);
endmodule
bind cec_error_confinement cec_error_confinement_sva u_chk (.clk(clk), .rst(rst), .bitTick(bitTick),
	.isTransmitter(isTransmitter), .errDetect(errDetect), .stuffErrArb(stuffErrArb), .flagStart(flagStart),
	.ackErrNoDom(ackErrNoDom),
	.txDone(txDone), .rxDone(rxDone), .faultState(faultState), .flagKind(flagKind), .txAllowed(txAllowed),
	.rxAllowed(rxAllowed), .transmitFaultCount(transmitFaultCount), .receiveFaultCount(receiveFaultCount));

// ==== tb/cec_error_confinement_tb_top.sv ====
`timescale 1ns/10ps
module cec_error_confinement_tb_top;
	logic clk = 1'b0, rst = 1'b1, en = 1'b0, lvl = 1'b1, bitTick, rxBit, txAllowed, rxAllowed;
	logic isTransmitter = 1'b0, errDetect = 1'b0, stuffErrArb = 1'b0, flagStart = 1'b0;
	logic txDone = 1'b0, rxDone = 1'b0, txRequest = 1'b0;
	logic bitErrInFlag = 1'b0, ackErrNoDom = 1'b0, flagIsOverload = 1'b0, flagDone = 1'b0;
	cec_pkg::cec_state_t faultState;
	cec_pkg::cec_flag_t flagKind;
	logic [8:0] tc, rc;
	int tx = 0, rx = 0, err_total = 0, checks_done = 0, k, n;
	integer seed = 32'h70D49294;
	always #25 clk = ~clk;
	cec_bus_node partner (.clk(clk), .en(en), .lvl(lvl), .bitTick(bitTick), .rxBit(rxBit));
	cec_error_confinement DUT (.clk(clk), .rst(rst), .bitTick(bitTick), .rxBit(rxBit), .isTransmitter(isTransmitter),
		.errDetect(errDetect), .bitErrInFlag(bitErrInFlag), .ackErrNoDom(ackErrNoDom), .stuffErrArb(stuffErrArb),
		.flagStart(flagStart), .flagIsOverload(flagIsOverload), .flagDone(flagDone), .txDone(txDone), .rxDone(rxDone),
		.txRequest(txRequest), .faultState(faultState), .flagKind(flagKind), .txAllowed(txAllowed),
		.rxAllowed(rxAllowed), .transmitFaultCount(tc), .receiveFaultCount(rc));
	task automatic chk(input string s, input logic [8:0] e, input logic [8:0] g);
		checks_done++;
		if (g !== e) begin
			err_total++;
			$display("unexpected %s: expected %0h seen %0h", s, e, g);
		end
	endtask
	task automatic stop_test();
		$display("checks %0d mismatches %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	task automatic cmp();
		chk("tx count", tx[8:0], tc);
		chk("rx count", rx[8:0], rc);
		chk("state", {7'h00, tx > 255 ? 2'b10 : (tx > 127 || rx > 127) ? 2'b01 : 2'b00}, {7'h00, faultState});
	endtask
	// one-cycle event, then model update and compare
	task automatic ev(input logic t, f, s, d, r, b = 1'b0, fd = 1'b0, o = 1'b0, a = 1'b0);
		bit p;
		{isTransmitter, flagStart, errDetect, stuffErrArb, txDone, rxDone} = {t, f, f, s, d, r};
		{bitErrInFlag, flagDone, flagIsOverload, ackErrNoDom} = {b, fd, o, a};
		@(negedge clk);
		{flagStart, errDetect, stuffErrArb, txDone, rxDone} = 5'h00;
		{bitErrInFlag, flagDone, flagIsOverload, ackErrNoDom} = 4'h0;
		p = tx > 127 || rx > 127;
		if (tx < 256) begin
			if (f && t && !s && !(p && a)) tx += 8;
			if (f && !t && !b) rx += 1;
			if (b && t) tx += 8;
			if (b && !t) rx += 8;
			if (d && tx > 0) tx -= 1;
			if (r) rx = rx > 127 ? 127 : rx > 0 ? rx - 1 : 0;
		end
		cmp();
	endtask
	task automatic ticks(input int m);
		for (int i = 0; i < m; i++) begin
			k = 0;
			do begin
				@(negedge clk);
				k++;
			end while (!bitTick && k < 8);
			if (!bitTick) begin
				err_total++;
				stop_test();
			end
		end
	endtask
	initial begin
		repeat (10) @(posedge clk);
		@(negedge clk);
		rst = 1'b0;
		cmp();
		errDetect = 1'b1;
		#1 chk("flag", 9'h001, {7'h00, flagKind});
		repeat (17) ev(1, 1, 0, 0, 0);
		errDetect = 1'b1;
		#1 chk("flag", 9'h002, {7'h00, flagKind});
		ev(1, 1, 1, 0, 0);
		$display("tx errors done");
		txRequest = 1'b1;
		ev(1, 0, 0, 1, 0);
		en = 1'b1;
		chk("tx allowed", 9'h000, {8'h00, txAllowed});
		ticks(7);
		chk("tx allowed", 9'h000, {8'h00, txAllowed});
		ticks(1);
		chk("tx allowed", 9'h001, {8'h00, txAllowed});
		en = 1'b0;
		$display("suspend done");
		n = 128 + $unsigned($random(seed)) % 8;
		repeat (n) ev(0, 1, 0, 0, 0);
		ev(0, 0, 0, 0, 1);
		ev(0, 0, 0, 0, 1);
		ev(1, 1, 0, 1, 0);
		$display("rx errors done");
		repeat (15) ev(1, 1, 0, 0, 0);
		chk("links", 9'h000, {7'h00, txAllowed, rxAllowed});
		ev(1, 1, 0, 1, 1);
		$display("bus off done");
		en = 1'b1;
		ticks(1408);
		en = 1'b0;
		{tx, rx} = 0;
		cmp();
		chk("rx allowed", 9'h001, {8'h00, rxAllowed});
		$display("recovery done");
		ev(1, 1, 0, 0, 0);
		ev(1, 0, 0, 0, 0, 1);
		lvl = 1'b0;
		en = 1'b1;
		ticks(13);
		cmp();
		ticks(1);
		tx += 8;
		cmp();
		ticks(8);
		tx += 8;
		cmp();
		lvl = 1'b1;
		ticks(1);
		en = 1'b0;
		$display("active run done");
		ev(0, 1, 0, 0, 0, 1, 0, 1);
		ev(0, 0, 0, 0, 0, 0, 1);
		lvl = 1'b0;
		en = 1'b1;
		ticks(1);
		rx += 8;
		cmp();
		ticks(13);
		rx += 8;
		cmp();
		lvl = 1'b1;
		ticks(1);
		en = 1'b0;
		$display("receiver flag done");
		repeat (12) ev(1, 1, 0, 0, 0);
		ev(1, 1, 0, 0, 0, 0, 0, 0, 1);
		ev(1, 1, 0, 0, 0);
		ev(1, 0, 0, 0, 0, 0, 1);
		lvl = 1'b0;
		en = 1'b1;
		ticks(7);
		cmp();
		ticks(1);
		tx += 8;
		cmp();
		ticks(8);
		tx += 8;
		cmp();
		lvl = 1'b1;
		ticks(1);
		en = 1'b0;
		$display("passive run done");
		stop_test();
	end
endmodule
